// ---- verilog/tpw_pkg.sv ----
package tpw_pkg;

	// apb register byte offsets
	localparam logic [7:0] TPW_CTRL_OFS    = 8'h00;
	localparam logic [7:0] TPW_CMPA_OFS    = 8'h04;
	localparam logic [7:0] TPW_CMPB_OFS    = 8'h08;
	localparam logic [7:0] TPW_COUNT_OFS   = 8'h0c;
	localparam logic [7:0] TPW_STATUS_OFS  = 8'h10;

	// control register field positions
	localparam int TPW_WGM_LSB   = 0;
	localparam int TPW_CSEL_LSB  = 4;
	localparam int TPW_COMB_LSB  = 8;
	localparam int TPW_COMA_LSB  = 10;
	localparam int TPW_DIRA_BIT  = 12;
	localparam int TPW_DIRB_BIT  = 13;

	// status register field positions
	localparam int TPW_OVF_BIT   = 0;
	localparam int TPW_MFA_BIT   = 1;
	localparam int TPW_MFB_BIT   = 2;
	localparam int TPW_OCA_BIT   = 3;
	localparam int TPW_OCB_BIT   = 4;
	localparam int TPW_DOWN_BIT  = 5;

	// reset values
	localparam logic [31:0] TPW_CTRL_RST = 32'h0000_0000;
	localparam logic [7:0]  TPW_CMP_RST  = 8'h00;

	// counter limits
	localparam logic [7:0] TPW_BOTTOM = 8'h00;
	localparam logic [7:0] TPW_MAX    = 8'hff;

	// waveform modes
	localparam logic [2:0] TPW_WGM_PC_FF   = 3'h1;
	localparam logic [2:0] TPW_WGM_FAST_FF = 3'h3;
	localparam logic [2:0] TPW_WGM_PC_A    = 3'h5;
	localparam logic [2:0] TPW_WGM_FAST_A  = 3'h7;

	// compare output modes
	localparam logic [1:0] TPW_COM_OFF    = 2'h0;
	localparam logic [1:0] TPW_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TPW_COM_NONINV = 2'h2;
	localparam logic [1:0] TPW_COM_INV    = 2'h3;

	// prescaler selects: 0, 6 and 7 stopped, 1 to 5 give N = 1, 8, 64, 256, 1024
	localparam logic [2:0] TPW_CS_STOP = 3'h0;
	localparam logic [2:0] TPW_CS_1    = 3'h1;
	localparam logic [2:0] TPW_CS_8    = 3'h2;
	localparam logic [2:0] TPW_CS_64   = 3'h3;
	localparam logic [2:0] TPW_CS_256  = 3'h4;
	localparam logic [2:0] TPW_CS_1024 = 3'h5;
	localparam int TPW_PRE_W = 10;

	typedef struct packed {
		logic [1:0] mode;
		logic       out_dir;
	} tpw_chan_cfg_s;

	typedef struct packed {
		logic level;
		logic oe;
	} tpw_pin_s;

endpackage

// ---- verilog/tpw_timer.sv ----
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tpw_timer
	import tpw_pkg::*;
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// port pins
	output logic             chan_a_output,
	output logic             chan_a_oe,
	output logic             chan_b_output,
	output logic             chan_b_oe,
	output logic             chan_a_override,
	output logic             chan_b_override
);

	logic [31:0] ctrl_reg;
	logic [7:0]  cmpa_buf_reg, cmpb_buf_reg;
	logic [7:0]  cmpa_reg, cmpb_reg;
	logic [7:0]  counter_value_reg, counter_value_next;
	logic        down_reg, down_next;
	logic        overflow_flag_reg, chan_a_match_flag_reg, chan_b_match_flag_reg;
	logic        oca_reg, ocb_reg, oca_next, ocb_next;
	logic [TPW_PRE_W-1:0] pre_reg;
	logic        tick_reg;

	wire [2:0]  waveform_mode = ctrl_reg[TPW_WGM_LSB +: 3];
	wire [2:0]  csel          = ctrl_reg[TPW_CSEL_LSB +: 3];
	wire [1:0]  chan_a_output_mode = ctrl_reg[TPW_COMA_LSB +: 2];
	wire [1:0]  chan_b_output_mode = ctrl_reg[TPW_COMB_LSB +: 2];
	wire        waveform_mode_high_bit = waveform_mode[2];

	// apb decode
	wire        wr_en  = psel && penable && pwrite;
	wire        rd_hit = (paddr == TPW_CTRL_OFS) || (paddr == TPW_CMPA_OFS) || (paddr == TPW_CMPB_OFS)
		|| (paddr == TPW_COUNT_OFS) || (paddr == TPW_STATUS_OFS);
	wire        wr_ctrl = wr_en && (paddr == TPW_CTRL_OFS);
	wire        wr_cmpa = wr_en && (paddr == TPW_CMPA_OFS);
	wire        wr_cmpb = wr_en && (paddr == TPW_CMPB_OFS);
	wire        wr_cnt  = wr_en && (paddr == TPW_COUNT_OFS);
	wire        wr_stat = wr_en && (paddr == TPW_STATUS_OFS);

	// mode decode
	wire        mode_fast = (waveform_mode == TPW_WGM_FAST_FF) || (waveform_mode == TPW_WGM_FAST_A);
	wire        mode_pc   = (waveform_mode == TPW_WGM_PC_FF) || (waveform_mode == TPW_WGM_PC_A);
	wire        mode_pwm  = mode_fast || mode_pc;
	wire [7:0]  top       = waveform_mode_high_bit ? cmpa_reg : TPW_MAX;

	// prescaler: divider gives a one-cycle enable
	logic       pre_hit;
	always_comb begin
		case (csel)
			TPW_CS_1:    pre_hit = 1'b1;
			TPW_CS_8:    pre_hit = (pre_reg[2:0] == 3'h7);
			TPW_CS_64:   pre_hit = (pre_reg[5:0] == 6'h3f);
			TPW_CS_256:  pre_hit = (pre_reg[7:0] == 8'hff);
			TPW_CS_1024: pre_hit = (pre_reg == 10'h3ff);
			default:     pre_hit = 1'b0;
		endcase
	end
	wire        timer_clock_enable = tick_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			pre_reg  <= (csel == TPW_CS_STOP) ? '0 : pre_reg + 10'h001;
			tick_reg <= pre_hit && (csel != TPW_CS_STOP);
		end
	end

	// counter sequencing
	wire        at_top    = (counter_value_reg == top);
	wire        at_bottom = (counter_value_reg == TPW_BOTTOM);
	always_comb begin
		counter_value_next = counter_value_reg;
		down_next          = down_reg;
		if (mode_fast) begin
			counter_value_next = at_top ? TPW_BOTTOM : counter_value_reg + 8'h01;
			down_next          = 1'b0;
		end else if (mode_pc) begin
			if (!down_reg) begin
				if (at_top) begin
					down_next          = 1'b1;
					counter_value_next = (top == TPW_BOTTOM) ? TPW_BOTTOM : counter_value_reg - 8'h01;
				end else begin
					counter_value_next = counter_value_reg + 8'h01;
				end
			end else begin
				if (at_bottom) begin
					down_next          = 1'b0;
					counter_value_next = (top == TPW_BOTTOM) ? TPW_BOTTOM : 8'h01;
				end else begin
					counter_value_next = counter_value_reg - 8'h01;
				end
			end
		end else begin
			counter_value_next = counter_value_reg + 8'h01;
			down_next          = 1'b0;
		end
	end

	// fast pwm: polarity level at match, opposite level at wrap
	function automatic logic fast_next(input logic cur, input logic up_lvl, input logic match,
		input logic [7:0] cmp, input logic wrap);
		logic r;
		r = cur;
		if (cmp == TPW_MAX) begin
			// match at max is ignored, the level is fixed at wrap
			if (wrap)
				r = ~up_lvl;
		end else if (wrap && !(match && cmp == TPW_BOTTOM)) begin
			r = ~up_lvl;
		end else if (match) begin
			r = up_lvl;
		end
		return r;
	endfunction

	// phase correct: extremes give constant levels, matches act by direction
	function automatic logic pc_next(input logic cur, input logic up_lvl, input logic match,
		input logic [7:0] cmp, input logic cnt_down, input logic pc_bottom, input logic pc_top);
		logic r;
		r = cur;
		if (cmp == TPW_MAX) begin
			// a match at max is ignored; the down-count level is applied at top
			if (pc_top)
				r = ~up_lvl;
		end else if (cmp == TPW_BOTTOM) begin
			// a match at bottom is ignored; the up-count level is applied there
			if (pc_bottom)
				r = up_lvl;
		end else if (match) begin
			r = cnt_down ? ~up_lvl : up_lvl;
		end else if (pc_bottom) begin
			// restores the level below the match, so a missed down match is still applied
			r = ~up_lvl;
		end
		return r;
	endfunction

	// compare output level logic per channel
	function automatic logic out_next(input logic cur, input logic [1:0] mode, input logic toggle_ok,
		input logic match, input logic [7:0] cmp, input logic cnt_down, input logic fast,
		input logic pc, input logic wrap, input logic pc_bottom, input logic pc_top);
		logic up_lvl;
		logic r;
		r = cur;
		up_lvl = (mode == TPW_COM_INV);
		if (mode == TPW_COM_OFF) begin
			r = cur;
		end else if (mode == TPW_COM_TOGGLE) begin
			if (toggle_ok && (fast || pc) && match)
				r = ~cur;
		end else if (fast) begin
			r = fast_next(cur, up_lvl, match, cmp, wrap);
		end else if (pc) begin
			r = pc_next(cur, up_lvl, match, cmp, cnt_down, pc_bottom, pc_top);
		end
		return r;
	endfunction

	wire match_a = (counter_value_reg == cmpa_reg);
	wire match_b = (counter_value_reg == cmpb_reg);
	wire wrap    = mode_fast && at_top;
	wire pc_bot  = mode_pc && down_reg && at_bottom;
	wire pc_top  = mode_pc && !down_reg && at_top;
	always_comb begin
		oca_next = out_next(oca_reg, chan_a_output_mode, waveform_mode_high_bit, match_a, cmpa_reg, down_reg,
			mode_fast, mode_pc, wrap, pc_bot, pc_top);
		ocb_next = out_next(ocb_reg, chan_b_output_mode, 1'b0, match_b, cmpb_reg, down_reg,
			mode_fast, mode_pc, wrap, pc_bot, pc_top);
	end

	// buffer update point: top in fast/pc, immediate otherwise
	wire upd_pt = !mode_pwm || (mode_fast && at_top) || pc_top;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value_reg <= TPW_BOTTOM;
			down_reg          <= 1'b0;
			oca_reg           <= 1'b0;
			ocb_reg           <= 1'b0;
			cmpa_reg          <= TPW_CMP_RST;
			cmpb_reg          <= TPW_CMP_RST;
		end else begin
			if (wr_cnt) begin
				counter_value_reg <= pwdata[7:0];
			end else if (timer_clock_enable) begin
				counter_value_reg <= counter_value_next;
				down_reg          <= down_next;
				oca_reg           <= oca_next;
				ocb_reg           <= ocb_next;
				if (upd_pt) begin
					cmpa_reg <= cmpa_buf_reg;
					cmpb_reg <= cmpb_buf_reg;
				end
			end
		end
	end

	// flags: hardware set wins over software clear
	wire ovf_set = timer_clock_enable && ((mode_fast && at_top) || pc_bot
		|| (!mode_pwm && counter_value_reg == TPW_MAX));
	wire mfa_set = timer_clock_enable && match_a;
	wire mfb_set = timer_clock_enable && match_b;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_reg     <= 1'b0;
			chan_a_match_flag_reg <= 1'b0;
			chan_b_match_flag_reg <= 1'b0;
		end else begin
			overflow_flag_reg     <= ovf_set || (overflow_flag_reg && !(wr_stat && pwdata[TPW_OVF_BIT]));
			chan_a_match_flag_reg <= mfa_set || (chan_a_match_flag_reg && !(wr_stat && pwdata[TPW_MFA_BIT]));
			chan_b_match_flag_reg <= mfb_set || (chan_b_match_flag_reg && !(wr_stat && pwdata[TPW_MFB_BIT]));
		end
	end

	// control and buffer writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= TPW_CTRL_RST;
			cmpa_buf_reg <= TPW_CMP_RST;
			cmpb_buf_reg <= TPW_CMP_RST;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= pwdata & 32'h0000_3f77;
			if (wr_cmpa)
				cmpa_buf_reg <= pwdata[7:0];
			if (wr_cmpb)
				cmpb_buf_reg <= pwdata[7:0];
		end
	end

	// read mux
	wire [31:0] status_word = {26'h0, down_reg, ocb_reg, oca_reg, chan_b_match_flag_reg,
		chan_a_match_flag_reg, overflow_flag_reg};
	wire [31:0] rd_word =
		(paddr == TPW_CTRL_OFS)   ? ctrl_reg :
		(paddr == TPW_CMPA_OFS)   ? {24'h0, cmpa_buf_reg} :
		(paddr == TPW_CMPB_OFS)   ? {24'h0, cmpb_buf_reg} :
		(paddr == TPW_COUNT_OFS)  ? {24'h0, counter_value_reg} :
		(paddr == TPW_STATUS_OFS) ? status_word : 32'h0000_0000;

	// per-channel configuration travels as one struct
	tpw_chan_cfg_s cfg_a;
	tpw_chan_cfg_s cfg_b;
	assign cfg_a = {chan_a_output_mode, ctrl_reg[TPW_DIRA_BIT]};
	assign cfg_b = {chan_b_output_mode, ctrl_reg[TPW_DIRB_BIT]};

	// pin override: level visible only when direction out
	wire ovr_a = (chan_a_output_mode != TPW_COM_OFF)
		&& !(chan_a_output_mode == TPW_COM_TOGGLE && mode_pwm && !waveform_mode_high_bit);
	wire ovr_b = (chan_b_output_mode != TPW_COM_OFF)
		&& !(chan_b_output_mode == TPW_COM_TOGGLE && mode_pwm);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
			chan_a_output   <= 1'b0;
			chan_a_oe       <= 1'b0;
			chan_b_output   <= 1'b0;
			chan_b_oe       <= 1'b0;
			chan_a_override <= 1'b0;
			chan_b_override <= 1'b0;
		end else begin
			pready          <= psel && !penable;
			pslverr         <= psel && !penable && !rd_hit;
			prdata          <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
			chan_a_output   <= oca_reg;
			chan_b_output   <= ocb_reg;
			chan_a_override <= ovr_a;
			chan_b_override <= ovr_b;
			chan_a_oe       <= ovr_a && cfg_a.out_dir;
			chan_b_oe       <= ovr_b && cfg_b.out_dir;
		end
	end

endmodule // tpw_timer

// ---- testbench/tpw_pin_load.sv ----
`timescale 1ns/1ps
module tpw_pin_load
	import tpw_pkg::*;
#(
	parameter logic PULL = 1'b1
)(
	// driver side
	input  wire tpw_pin_s drv,
	// pad
	output logic          pin
);
	// released pin floats to the pull-up level
	assign pin = drv.oe ? drv.level : PULL;
endmodule // tpw_pin_load

// ---- testbench/tpw_timer_props.sv ----
`timescale 1ns/1ps
module tpw_timer_props (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        chan_a_output,
	input wire logic        chan_a_oe,
	input wire logic        chan_a_override,
	input wire logic        chan_b_oe,
	input wire logic        chan_b_override
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_data_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_oe_own_a: assert property (chan_a_oe |-> chan_a_override)
		else $error("pin a driven without override");
	a_oe_own_b: assert property (chan_b_oe |-> chan_b_override)
		else $error("pin b driven without override");
	a_reset_level: assert property ($rose(presetn) |-> !chan_a_output && !chan_a_oe)
		else $error("compare output not cleared by reset");
endmodule // tpw_timer_props

bind tpw_timer tpw_timer_props u_props (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
	.chan_a_output, .chan_a_oe, .chan_a_override, .chan_b_oe, .chan_b_override);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import tpw_pkg::*;
	localparam int WG[6] = '{3, 3, 1, 1, 7, 5};
	localparam int CM[6] = '{2, 3, 2, 3, 1, 1};
	localparam int CS[6] = '{1, 2, 1, 1, 2, 1};
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        chan_a_output;
	logic        chan_a_oe;
	logic        chan_b_output;
	logic        chan_b_oe;
	logic        chan_a_override;
	logic        chan_b_override;
	logic        pin_a;
	logic        pin_b;
	logic [31:0] rd;
	logic        er;
	int          err_count   = 0;
	int          checks_done = 0;

	always #2.5 pclk = ~pclk;

	tpw_timer u_tpw_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .chan_a_output, .chan_a_oe, .chan_b_output, .chan_b_oe, .chan_a_override, .chan_b_override);
	tpw_pin_load u_load_a (.drv({chan_a_output, chan_a_oe}), .pin(pin_a));
	tpw_pin_load u_load_b (.drv({chan_b_output, chan_b_oe}), .pin(pin_b));

	task automatic summarize();
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		check("pready", 1, pready);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// length of one steady-state window and the high time expected in it
	function automatic int win_len(int wg, int c, int n);
		if (wg == 7) return 2 * (c + 1) * n;
		if (wg == 5) return 4 * c * n;
		return (wg == 1 ? 510 : 256) * n;
	endfunction

	function automatic int high_len(int wg, int com, int c, int n);
		int h;
		if (com == 1) return win_len(wg, c, n) / 2;
		h = (wg == 1) ? 2 * c * n : (c + 1) * n;
		return (com == 3) ? win_len(wg, c, n) - h : h;
	endfunction

	initial begin
		repeat (60000) @(posedge pclk);
		err_count++;
		summarize();
	end

	initial begin
		int c, n, cb, w, ha, hb;
		void'($urandom(2));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("output a at reset", 0, chan_a_output);
		apb(1'b0, TPW_CTRL_OFS, 32'h0);
		check("ctrl reset", TPW_CTRL_RST, rd);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped error", 1, er);
		check("unmapped data", 0, rd);
		for (int i = 0; i < 6; i++) begin
			c = (i == 0 || i == 3) ? 0 : (i == 2) ? 255 : (WG[i] >= 5) ? 1 + $urandom % 15 : $urandom % 256;
			n = (CS[i] == 1) ? 1 : 8;
			cb = (CM[i] == 1) ? 1 : CM[i] ^ 1;
			apb(1'b1, TPW_CMPA_OFS, c);
			apb(1'b1, TPW_CMPB_OFS, c);
			apb(1'b1, TPW_CTRL_OFS, WG[i] | CS[i] << 4 | cb << 8 | CM[i] << 10 | 3 << 12);
			apb(1'b1, TPW_STATUS_OFS, 32'h1);
			w = win_len(WG[i], c, n);
			repeat (2 * w + 520 * n) @(posedge pclk);
			ha = 0;
			hb = 0;
			repeat (w) begin
				@(posedge pclk);
				ha += pin_a;
				hb += pin_b;
			end
			check("high time a", high_len(WG[i], CM[i], c, n), ha);
			if (CM[i] == 1) check("override b", 0, chan_b_override);
			else check("high time b", high_len(WG[i], cb, c, n), hb);
			apb(1'b0, TPW_STATUS_OFS, 32'h0);
			check("overflow flag", 1, rd[TPW_OVF_BIT]);
		end
		apb(1'b1, TPW_CTRL_OFS, TPW_WGM_FAST_FF | TPW_CS_1 << 4 | TPW_COM_TOGGLE << 8 | TPW_COM_NONINV << 10);
		repeat (2) @(posedge pclk);
		check("override a", 1, chan_a_override);
		check("pin a released", 1, pin_a);
		check("override b reserved", 0, chan_b_override);
		apb(1'b1, TPW_CTRL_OFS, TPW_WGM_FAST_FF | TPW_CS_1 << 4 | TPW_COM_TOGGLE << 10 | 1 << 12);
		repeat (2) @(posedge pclk);
		check("toggle without high bit", 0, chan_a_override);
		check("pin a normal port", 1, pin_a);
		summarize();
	end
endmodule // tb_top
